/* File: src/apr_cfg.svh */
// Purpose: constants of the converter readout block
// Assumes: 200 MHz core clock
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef APR_CFG_SVH
`define APR_CFG_SVH

`define APR_CLK_PERIOD_PS 5000
// Least time the start condition must stand before it is taken
`define APR_START_MIN_NS 40
`define APR_START_CYC \
   ((`APR_START_MIN_NS * 1000 + `APR_CLK_PERIOD_PS - 1) / `APR_CLK_PERIOD_PS)
// Internal conversion time of the successive-approximation core
`define APR_CONV_TIME_NS 3000
`define APR_CONV_CYC \
   ((`APR_CONV_TIME_NS * 1000 + `APR_CLK_PERIOD_PS - 1) / `APR_CLK_PERIOD_PS)

`define APR_RESULT_W 16
`define APR_BYTE_W 8
`define APR_FIFO_DEPTH 32
`define APR_RESULT_RST 16'h0000

`endif

/* File: src/apr_pkg.sv */
// Purpose: types of the converter readout block
// Assumes: nothing
// Notes: one-hot conversion sequencer states
package apr_pkg;
   typedef enum logic [2:0] {
      APR_IDLE = 3'b001,
      APR_CONV = 3'b010,
      APR_PUSH = 3'b100
   } apr_state_t;
endpackage

/* File: src/apr_fifo.sv */
// Purpose: result FIFO between the conversion core and the output register
// Assumes: one clock, synchronous active-low reset
// Notes: valid/ready on both sides; count shows the occupancy
`timescale 1ns/1ps
module apr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic push;
   logic pop;

   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

/* File: src/apr_readout.sv */
// Purpose: conversion control and parallel readout of a 16-bit converter
// Assumes: host pins are asynchronous and pass two flip-flops first
// Notes: the SAR core's code arrives on sarCode in straight binary
`timescale 1ns/1ps
`include "apr_cfg.svh"
module apr_readout (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic csN,
   input wire logic readConvert,
   input wire logic byteSel,
   input wire logic [`APR_RESULT_W-1:0] sarCode,
   output logic busyN,
   output logic sampleHold,
   output logic [`APR_RESULT_W-1:0] dataOut,
   output logic dataOe
);
   localparam int START_CYC = `APR_START_CYC;
   localparam int CONV_CYC = `APR_CONV_CYC;
   localparam int RW = `APR_RESULT_W;
   localparam int BW = `APR_BYTE_W;

   function automatic logic [RW-1:0] laneOrder(input logic [RW-1:0] w,
                                                input logic swap);
      laneOrder = swap ? {w[BW-1:0], w[RW-1:BW]} : w;
   endfunction

   //--------------------------------------------------
   // Pin synchronisers
   //--------------------------------------------------
   logic [2:0] pinMeta;
   logic csQ;
   logic rcQ;
   logic byteQ;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pinMeta <= 3'h6;
         csQ <= 1'b1;
         rcQ <= 1'b1;
         byteQ <= 1'b0;
      end else begin
         pinMeta <= {csN, readConvert, byteSel};
         csQ <= pinMeta[2];
         rcQ <= pinMeta[1];
         byteQ <= pinMeta[0];
      end
   end

   //--------------------------------------------------
   // Start detection
   //--------------------------------------------------
   // Level triggered AND of the two strobes, both low; held low long enough to count
   logic startCond;
   logic [3:0] lowCnt;
   logic start;

   assign startCond = !csQ && !rcQ;
   assign start = startCond && (lowCnt == 4'(START_CYC - 1));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lowCnt <= 4'h0;
      end else if (!startCond) begin
         lowCnt <= 4'h0;
      end else if (lowCnt != 4'(START_CYC)) begin
         lowCnt <= lowCnt + 4'h1;
      end
   end

   //--------------------------------------------------
   // Conversion sequencer
   //--------------------------------------------------
   apr_pkg::apr_state_t state;
   logic [9:0] convCnt;
   logic [RW-1:0] pushData;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [RW-1:0] fifoOutData;
   logic [$clog2(`APR_FIFO_DEPTH):0] fifoCount;
   logic convDone;

   assign convDone = (state == apr_pkg::APR_CONV) &&
                     (convCnt == 10'(CONV_CYC - 1));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= apr_pkg::APR_IDLE;
         convCnt <= 10'h000;
      end else if (start) begin
         // A fresh start wins over everything, aborting any work in flight
         state <= apr_pkg::APR_CONV;
         convCnt <= 10'h000;
      end else begin
         case (state)
            apr_pkg::APR_IDLE: begin
               convCnt <= 10'h000;
            end
            apr_pkg::APR_CONV: begin
               convCnt <= convCnt + 10'h001;
               if (convDone) begin
                  state <= apr_pkg::APR_PUSH;
               end
            end
            apr_pkg::APR_PUSH: begin
               // Waits here while the FIFO is full
               if (fifoInReady) begin
                  state <= apr_pkg::APR_IDLE;
               end
            end
            default: begin
               state <= apr_pkg::APR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pushData <= `APR_RESULT_RST;
      end else if (convDone && !start) begin
         pushData <= {~sarCode[RW-1], sarCode[RW-2:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sampleHold <= 1'b0;
      end else begin
         sampleHold <= start || (state == apr_pkg::APR_CONV && !convDone);
      end
   end

   //--------------------------------------------------
   // Result FIFO and output register
   //--------------------------------------------------
   logic [RW-1:0] outReg;
   logic outLoad;

   apr_fifo #(
      .WIDTH(RW),
      .DEPTH(`APR_FIFO_DEPTH)
   ) i_apr_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(state == apr_pkg::APR_PUSH && !start),
      .inReady(fifoInReady),
      .inData(pushData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData),
      .count(fifoCount)
   );

   // The register must not change under a host that is reading valid data
   assign fifoOutReady = !dataOe || !busyN;
   assign outLoad = fifoOutValid && fifoOutReady;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         outReg <= `APR_RESULT_RST;
      end else if (outLoad) begin
         outReg <= fifoOutData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busyN <= 1'b1;
      end else if (start) begin
         busyN <= 1'b0;
      end else if (outLoad && fifoCount == 6'd1 &&
                   state == apr_pkg::APR_IDLE) begin
         busyN <= 1'b1;
      end
   end

   //--------------------------------------------------
   // Parallel output drivers
   //--------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dataOe <= 1'b0;
         dataOut <= `APR_RESULT_RST;
      end else begin
         dataOe <= !csQ && rcQ;
         // Bit 15 sits on the top lane unless the low byte is asked for
         dataOut <= laneOrder(outReg, byteQ);
      end
   end

   //--------------------------------------------------
   // Assertions
   //--------------------------------------------------
   property p_busy_on_start;
      @(posedge clk) disable iff (!rst_n)
      start |=> !busyN;
   endproperty
   a_busy_on_start: assert property (p_busy_on_start)
      else $error("busy did not fall at conversion start");

   property p_busy_rise_cause;
      @(posedge clk) disable iff (!rst_n)
      $rose(busyN) |-> $past(outLoad) && $past(fifoCount) == 6'd1;
   endproperty
   a_busy_rise_cause: assert property (p_busy_rise_cause)
      else $error("busy rose without the output register update");

   property p_conv_len;
      @(posedge clk) disable iff (!rst_n)
      (start ##1 (!start)[*8]) |-> state == apr_pkg::APR_CONV;
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("conversion ended too early");

   property p_byte_lane;
      @(posedge clk) disable iff (!rst_n)
      1'b1 |=> dataOut[RW-1:BW] ==
         ($past(byteQ) ? $past(outReg[BW-1:0]) : $past(outReg[RW-1:BW]));
   endproperty
   a_byte_lane: assert property (p_byte_lane)
      else $error("byte lane carries the wrong half");

   property p_start_taken;
      @(posedge clk) disable iff (!rst_n)
      (!startCond ##1 startCond[*8]) |-> start;
   endproperty
   a_start_taken: assert property (p_start_taken)
      else $error("held start condition did not start a conversion");

   property p_oe_off;
      @(posedge clk) disable iff (!rst_n)
      (csQ || !rcQ) |=> !dataOe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("drivers on while deselected or converting");

   property p_oe_on;
      @(posedge clk) disable iff (!rst_n)
      $rose(rcQ) && !csQ ##1 !csQ && rcQ |-> dataOe;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("read edge did not enable the drivers");

   property p_twos;
      @(posedge clk) disable iff (!rst_n)
      convDone && !start |=> pushData == {~$past(sarCode[RW-1]),
                                         $past(sarCode[RW-2:0])};
   endproperty
   a_twos: assert property (p_twos)
      else $error("result not in two's complement");

   property p_abort;
      @(posedge clk) disable iff (!rst_n)
      start && state != apr_pkg::APR_IDLE |=>
         state == apr_pkg::APR_CONV && convCnt == 10'h000 && !busyN;
   endproperty
   a_abort: assert property (p_abort)
      else $error("new command did not restart the conversion");

   property p_hold;
      @(posedge clk) disable iff (!rst_n)
      !outLoad |=> $stable(outReg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("output register changed without a new result");

   c_abort: cover property (@(posedge clk) disable iff (!rst_n)
      start && state == apr_pkg::APR_CONV);
   c_done: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(busyN));
   c_read: cover property (@(posedge clk) disable iff (!rst_n)
      dataOe && byteQ);
endmodule

/* File: tb/apr_host_model.sv */
// Purpose: host controller driving the converter's control pins
// Assumes: pins change just after the rising clock edge
// Notes: sarCode stands in for the analog core, held over a conversion
`timescale 1ns/1ps
module apr_host_model (
   input wire logic clk,
   output logic csN,
   output logic readConvert,
   output logic byteSel,
   output logic [15:0] sarCode
);
   initial begin
      csN = 1'b1;
      readConvert = 1'b1;
      byteSel = 1'b0;
      sarCode = 16'h0000;
   end

   // ----------------------------------------
   // Convert command, then stay selected to read
   // ----------------------------------------
   task automatic pulse(input logic [15:0] code, input int lowCyc);
      @(posedge clk);
      sarCode <= code;
      csN <= 1'b0;
      readConvert <= 1'b0;
      repeat (lowCyc) @(posedge clk);
      readConvert <= 1'b1;
   endtask

   task automatic deselect();
      @(posedge clk);
      csN <= 1'b1;
   endtask

   task automatic setByte(input logic b);
      @(posedge clk);
      byteSel <= b;
   endtask
endmodule

/* File: tb/adc_parallel_readout_control_bench.sv */
// Purpose: self-checking bench of the converter readout block
// Assumes: 200 MHz clock, synchronous active-low reset
// Notes: conversion takes about 600 cycles, no count is shortened
`timescale 1ns/1ps
module adc_parallel_readout_control_bench;
   logic clk;
   logic rst_n;
   logic csN;
   logic readConvert;
   logic byteSel;
   logic [15:0] sarCode;
   logic busyN;
   logic sampleHold;
   logic [15:0] dataOut;
   logic dataOe;
   int error_cnt = 0;
   int n_compared = 0;
   logic [15:0] prev = 16'h0000;

   apr_readout i_apr_readout (.clk(clk), .rst_n(rst_n), .csN(csN),
      .readConvert(readConvert), .byteSel(byteSel), .sarCode(sarCode),
      .busyN(busyN), .sampleHold(sampleHold), .dataOut(dataOut),
      .dataOe(dataOe));
   apr_host_model i_apr_host_model (.clk(clk), .csN(csN),
      .readConvert(readConvert), .byteSel(byteSel), .sarCode(sarCode));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   // Bounded wait; a level never reached shows up in the compare
   task automatic waitBusy(input logic lvl, input int lim);
      int n;
      n = 0;
      while (busyN !== lvl && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(busyN, lvl);
   endtask

   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic shortPulse();
      i_apr_host_model.pulse(16'h5555, 5);
      repeat (30) @(posedge clk);
      #1;
      check(busyN, 1'b1);
      i_apr_host_model.deselect();
   endtask

   task automatic convRead(input logic [15:0] code);
      logic [15:0] exp;
      exp = {~code[15], code[14:0]};
      i_apr_host_model.pulse(code, 10);
      waitBusy(1'b0, 20);
      check(sampleHold, 1'b1);
      check(dataOe, 1'b0);
      repeat (4) @(posedge clk);
      #1;
      check(dataOe, 1'b1);
      check(dataOut, prev);
      waitBusy(1'b1, 700);
      repeat (3) @(posedge clk);
      #1;
      check(dataOut, exp);
      i_apr_host_model.setByte(1'b1);
      repeat (4) @(posedge clk);
      #1;
      check(dataOut, {exp[7:0], exp[15:8]});
      i_apr_host_model.setByte(1'b0);
      i_apr_host_model.deselect();
      repeat (4) @(posedge clk);
      #1;
      check(dataOe, 1'b0);
      prev = exp;
   endtask

   // Second command 100 cycles in must restart the whole conversion
   task automatic abortConv();
      i_apr_host_model.pulse(16'h4000, 10);
      waitBusy(1'b0, 20);
      repeat (100) @(posedge clk);
      i_apr_host_model.pulse(16'hc0de, 10);
      repeat (540) @(posedge clk);
      #1;
      check(busyN, 1'b0);
      waitBusy(1'b1, 200);
      repeat (3) @(posedge clk);
      #1;
      check(dataOut, 16'h40de);
      i_apr_host_model.deselect();
      prev = 16'h40de;
   endtask

   initial begin
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      check(busyN, 1'b1);
      check(dataOe, 1'b0);
      repeat (4) @(posedge clk);
      shortPulse();
      convRead(16'h1234);
      convRead(16'hf00d);
      convRead(16'h0000);
      abortConv();
      end_sim();
   end

   // Tests need about 2700 cycles
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
endmodule
